// ---- reset_and_brownout_control.sv ----
// Reset sequencer with power-up delay and a four-mode brown-out detector.
// Operation
// - Power, brown-out, low-power brown-out, pin, watchdog, instruction, stack, programming exit all reset.
// - Reset holds while the supply is below the power-on operating level.
// - Enabled power-up delay holds reset 64 ms after power-on or brown-out.
// - Power-up delay configuration bit is active low; set bit skips the delay.
// - Power-up delay starts only after power-on and brown-out both released.
// - Brown-out holds reset at the threshold; one bit picks the level.
// - Brown-out trips only after the supply stays low past the filter time.
// - Mode 11 keeps the detector on always; start waits, wake does not.
// - Mode 10 turns detector off in sleep; start and wake wait ready.
// - Mode 01 lets software enable switch the detector; no start wait.
// - Mode 00, or 01 with enable clear, disables detector; run at once.
// - Software mode protection begins once ready; ready bit shows it.
// - Ready bit reads one once the active detector has settled, else zero.
// - Software enable is always read-write but acts only in mode 01.
// - Fast start forces the reference on in modes 10 and 01 only.
// - Forced-on detector adds no delay; ready is set before execution.
// - Low-power brown-out request ORs with brown-out to the combined signal.
`include "reset_and_brownout_control_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module reset_and_brownout_control #(
    parameter int POWERUP_DELAY_TIMER_CYCLES = `RBC_POWERUP_DELAY_TIMER_MS * 1000000 / `RBC_CLK_NS
) (
    input  wire logic                                      mclk,
    input  wire logic                                      rst_b,
    input  wire logic                                      por_supply_ok,
    input  wire logic                                      supply_below_threshold,
    input  wire logic                                      lowpower_brownout_en,
    input  wire logic                                      lowpower_brownout_req,
    input  wire logic                                      external_reset_pin_en,
    input  wire logic                                      external_reset_pin_b,
    input  wire logic                                      watchdog_reset_req,
    input  wire logic                                      reset_instr_req,
    input  wire logic                                      stack_overflow_req,
    input  wire logic                                      stack_underflow_req,
    input  wire logic                                      prog_mode_exit,
    input  wire logic                                      sleep_mode,
    input  wire reset_and_brownout_control_pkg::bor_mode_t brownout_mode_sel,
    input  wire logic                                      brownout_level_sel,
    input  wire logic                                      powerup_delay_enable_n,
    input  wire logic [`RBC_ADDR_W-1:0]                    reg_addr,
    input  wire logic [`RBC_DATA_W-1:0]                    reg_wr_data,
    input  wire logic                                      reg_wr_en,
    input  wire logic                                      reg_rd_en,
    output logic      [`RBC_DATA_W-1:0]                    reg_rd_data,
    output logic                                           device_reset,
    output logic                                           brownout_detector_on,
    output logic                                           bandgap_on,
    output logic                                           brownout_level_out,
    output logic                                           combined_brownout
);
    import reset_and_brownout_control_pkg::*;

    localparam logic [`RBC_FILTER_W-1:0] FILTER_CYC = `RBC_FILTER_W'(`RBC_FILTER_NS / `RBC_CLK_NS);
    localparam logic [`RBC_SETTLE_W-1:0] SETTLE_CYC =
        `RBC_SETTLE_W'((`RBC_SETTLE_NS + `RBC_CLK_NS - 1) / `RBC_CLK_NS);
    localparam logic [`RBC_POWERUP_DELAY_TIMER_W-1:0]   POWERUP_DELAY_TIMER_LAST  = `RBC_POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_CYCLES - 1);

    seq_state_t                state_reg;
    seq_state_t                state_next;
    logic [`RBC_POWERUP_DELAY_TIMER_W-1:0]    timer_reg;
    logic [`RBC_POWERUP_DELAY_TIMER_W-1:0]    timer_next;
    logic [`RBC_FILTER_W-1:0]  filt_reg;
    logic [`RBC_FILTER_W-1:0]  filt_next;
    logic [`RBC_SETTLE_W-1:0]  settle_reg;
    logic [`RBC_SETTLE_W-1:0]  settle_next;
    logic                      swen_reg;
    logic                      swen_next;
    logic                      fs_reg;
    logic                      fs_next;
    logic [`RBC_DATA_W-1:0]    rd_data_reg;
    logic [`RBC_DATA_W-1:0]    rd_data_next;
    logic                      device_reset_reg;
    logic                      device_reset_next;
    logic                      det_on_reg;
    logic                      bg_on_reg;
    logic                      level_reg;
    logic                      comb_bor_reg;
    logic                      active;
    logic                      fs_act;
    logic                      bg_on_w;
    logic                      ready;
    logic                      bor_trip;
    logic                      comb_bor;
    logic                      power_src;
    logic                      other_src;
    logic                      wait_ready;
    logic                      sel_hit;

    always_comb begin
        // Detector power by mode.
        active = (brownout_mode_sel == BOR_ON) ||
                 ((brownout_mode_sel == BOR_NOSLEEP) && !sleep_mode) ||
                 ((brownout_mode_sel == BOR_SW) && swen_reg);
        fs_act  = fs_reg && ((brownout_mode_sel == BOR_NOSLEEP) || (brownout_mode_sel == BOR_SW));
        bg_on_w = active || fs_act;
        if (!bg_on_w) begin
            settle_next = '0;
        end else if (settle_reg == SETTLE_CYC) begin
            settle_next = settle_reg;
        end else begin
            settle_next = settle_reg + `RBC_SETTLE_W'(1);
        end
        ready = (settle_reg == SETTLE_CYC) && active;
        // Supply dip filter; only a dip longer than the filter time trips.
        if (active && ready && supply_below_threshold) begin
            filt_next = (filt_reg == FILTER_CYC) ? filt_reg : filt_reg + `RBC_FILTER_W'(1);
        end else begin
            filt_next = '0;
        end
        bor_trip  = (filt_reg == FILTER_CYC);
        comb_bor  = bor_trip || (lowpower_brownout_en && lowpower_brownout_req);
        power_src = !por_supply_ok || comb_bor || prog_mode_exit;
        other_src = (external_reset_pin_en && !external_reset_pin_b) || watchdog_reset_req ||
                    reset_instr_req || stack_overflow_req || stack_underflow_req;
        wait_ready = ((brownout_mode_sel == BOR_ON) &&
                      (!ready || (supply_below_threshold && device_reset_reg))) ||
                     ((brownout_mode_sel == BOR_NOSLEEP) && !sleep_mode && !ready);
        // Power-up sequence.
        state_next = state_reg;
        timer_next = timer_reg;
        case (state_reg)
            S_POWER: begin
                timer_next = '0;
                if (!power_src) begin
                    state_next = powerup_delay_enable_n ? S_RUN : S_TIMER;
                end
            end
            S_TIMER: begin
                if (power_src) begin
                    state_next = S_POWER;
                    timer_next = '0;
                end else if (timer_reg == POWERUP_DELAY_TIMER_LAST) begin
                    state_next = S_RUN;
                end else begin
                    timer_next = timer_reg + `RBC_POWERUP_DELAY_TIMER_W'(1);
                end
            end
            S_RUN: begin
                if (power_src) begin
                    state_next = S_POWER;
                    timer_next = '0;
                end
            end
            default: begin
                state_next = S_POWER;
                timer_next = '0;
            end
        endcase
        device_reset_next = power_src || other_src || (state_next != S_RUN) || wait_ready;
        // Register port.
        sel_hit   = (reg_addr == `RBC_BORCS_OFS);
        swen_next = swen_reg;
        fs_next   = fs_reg;
        if (comb_bor) begin
            swen_next = 1'(`RBC_BORCS_RST >> `RBC_SWEN_BIT);
            fs_next   = 1'(`RBC_BORCS_RST >> `RBC_FS_BIT);
        end else if (reg_wr_en && sel_hit) begin
            swen_next = reg_wr_data[`RBC_SWEN_BIT];
            fs_next   = reg_wr_data[`RBC_FS_BIT];
        end
        rd_data_next = '0;
        if (reg_rd_en && sel_hit) begin
            rd_data_next[`RBC_SWEN_BIT] = swen_reg;
            rd_data_next[`RBC_FS_BIT]   = fs_reg;
            rd_data_next[`RBC_RDY_BIT]  = ready;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg        <= S_POWER;
            timer_reg        <= '0;
            filt_reg         <= '0;
            settle_reg       <= '0;
            swen_reg         <= 1'(`RBC_BORCS_RST >> `RBC_SWEN_BIT);
            fs_reg           <= 1'(`RBC_BORCS_RST >> `RBC_FS_BIT);
            rd_data_reg      <= '0;
            device_reset_reg <= 1'b1;
            det_on_reg       <= 1'b0;
            bg_on_reg        <= 1'b0;
            level_reg        <= 1'b0;
            comb_bor_reg     <= 1'b0;
        end else begin
            state_reg        <= state_next;
            timer_reg        <= timer_next;
            filt_reg         <= filt_next;
            settle_reg       <= settle_next;
            swen_reg         <= swen_next;
            fs_reg           <= fs_next;
            rd_data_reg      <= rd_data_next;
            device_reset_reg <= device_reset_next;
            det_on_reg       <= active;
            bg_on_reg        <= bg_on_w;
            level_reg        <= brownout_level_sel;
            comb_bor_reg     <= comb_bor;
        end
    end

    assign reg_rd_data          = rd_data_reg;
    assign device_reset         = device_reset_reg;
    assign brownout_detector_on = det_on_reg;
    assign bandgap_on           = bg_on_reg;
    assign brownout_level_out   = level_reg;
    assign combined_brownout    = comb_bor_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    AST_OTHER_SRC_RESETS: assert property (
        (watchdog_reset_req || reset_instr_req || stack_overflow_req || stack_underflow_req)
        |=> device_reset)
        else $error("Reset source did not assert device reset.");

    AST_POR_HOLDS: assert property (
        !por_supply_ok |=> device_reset && (state_reg == S_POWER))
        else $error("Low supply did not hold reset.");

    AST_TIMER_HOLDS: assert property (
        (state_reg == S_TIMER && timer_reg != POWERUP_DELAY_TIMER_LAST) |=> device_reset)
        else $error("Reset released while power-up delay ran.");

    AST_DELAY_SKIPPED: assert property (
        (state_reg == S_POWER && !power_src && powerup_delay_enable_n) |=> state_reg == S_RUN)
        else $error("Disabled power-up delay still ran.");

    AST_TIMER_START: assert property (
        (state_reg == S_POWER && !power_src && !powerup_delay_enable_n)
        |=> (state_reg == S_TIMER) && (timer_reg == '0))
        else $error("Power-up delay did not start from zero after release.");

    AST_DIP_FILTER: assert property (
        !supply_below_threshold |=> (filt_reg == '0) ##1 !bor_trip)
        else $error("Short dip reached the brown-out trip.");

    AST_ON_IN_SLEEP: assert property (
        (brownout_mode_sel == BOR_ON) && sleep_mode |=> brownout_detector_on)
        else $error("Always-on detector turned off in sleep.");

    AST_NOSLEEP_WAIT: assert property (
        (brownout_mode_sel == BOR_NOSLEEP) && !sleep_mode && !ready |=> device_reset)
        else $error("Mode 10 did not wait for detector ready.");

    AST_OFF_RUNS: assert property (
        (brownout_mode_sel == BOR_OFF) && !power_src && !other_src && state_reg == S_RUN
        |=> !device_reset && !brownout_detector_on)
        else $error("Disabled detector delayed execution.");

    AST_READY_READ: assert property (
        reg_rd_en && sel_hit |=> reg_rd_data[`RBC_RDY_BIT] == $past(ready))
        else $error("Ready bit read does not match detector state.");

    AST_SW_ENABLE: assert property (
        (brownout_mode_sel == BOR_SW) && swen_reg |=> brownout_detector_on)
        else $error("Software enable did not switch the detector on.");

    AST_FS_STORAGE: assert property (
        (brownout_mode_sel == BOR_OFF) |=> !bandgap_on)
        else $error("Fast start acted in the off mode.");

    AST_LP_COMBINED: assert property (
        lowpower_brownout_en && lowpower_brownout_req |=> combined_brownout && device_reset)
        else $error("Low-power brown-out did not reach the combined signal.");

    AST_DIP_NO_RESET: assert property (
        (brownout_mode_sel == BOR_ON) && ready && !power_src && !other_src && (state_reg == S_RUN) &&
        !device_reset |=> !device_reset)
        else $error("Short dip reset the running device.");

    AST_PIN_RESET: assert property (
        external_reset_pin_en && !external_reset_pin_b |=> device_reset)
        else $error("Enabled reset pin did not assert device reset.");

    AST_PROG_EXIT: assert property (
        prog_mode_exit |=> device_reset && (state_reg == S_POWER))
        else $error("Programming exit did not restart the power sequence.");

    AST_BOR_HOLDS: assert property (
        bor_trip |=> device_reset && combined_brownout)
        else $error("Brown-out trip did not hold reset.");

    AST_LEVEL_COPY: assert property (
        1'b1 |=> brownout_level_out == $past(brownout_level_sel))
        else $error("Threshold select did not reach its output.");

    AST_ON_START_WAIT: assert property (
        (brownout_mode_sel == BOR_ON) && (!ready || (supply_below_threshold && device_reset)) |=> device_reset)
        else $error("Always-on mode started before the detector was ready.");

    AST_NOSLEEP_OFF: assert property (
        (brownout_mode_sel == BOR_NOSLEEP) && sleep_mode |=> !brownout_detector_on)
        else $error("Mode 10 detector stayed on in sleep.");

    AST_SW_NO_WAIT: assert property (
        (brownout_mode_sel == BOR_SW) && !power_src && !other_src && (state_reg == S_RUN) |=> !device_reset)
        else $error("Software mode delayed execution.");

    AST_SW_DISABLED: assert property (
        (brownout_mode_sel == BOR_SW) && !swen_reg |=> !brownout_detector_on)
        else $error("Cleared software enable left the detector on.");

    AST_FS_FORCES: assert property (
        fs_reg && ((brownout_mode_sel == BOR_NOSLEEP) || (brownout_mode_sel == BOR_SW)) |=> bandgap_on)
        else $error("Fast start did not force the reference on.");

endmodule : reset_and_brownout_control
`default_nettype wire

// ---- reset_and_brownout_control_cfg.svh ----
// Register map, field positions, reset values and timing figures of the reset and brown-out block.
`ifndef RESET_AND_BROWNOUT_CONTROL_CFG_SVH
`define RESET_AND_BROWNOUT_CONTROL_CFG_SVH

`define RBC_ADDR_W       4
`define RBC_DATA_W       8
`define RBC_BORCS_OFS    4'h0
`define RBC_BORCS_RST    8'h80
`define RBC_SWEN_BIT     7
`define RBC_FS_BIT       6
`define RBC_RDY_BIT      0
`define RBC_CLK_NS       10
`define RBC_POWERUP_DELAY_TIMER_MS      64
`define RBC_POWERUP_DELAY_TIMER_W       23
`define RBC_FILTER_NS    1000
`define RBC_FILTER_W     8
`define RBC_SETTLE_NS    5000
`define RBC_SETTLE_W     10

`endif

// ---- reset_and_brownout_control_pkg.sv ----
// Types shared by the reset and brown-out block.
`default_nettype none
package reset_and_brownout_control_pkg;

    typedef enum logic [1:0] {
        BOR_OFF     = 2'b00,
        BOR_SW      = 2'b01,
        BOR_NOSLEEP = 2'b10,
        BOR_ON      = 2'b11
    } bor_mode_t;

    typedef enum logic [1:0] {
        S_POWER = 2'b00,
        S_TIMER = 2'b01,
        S_RUN   = 2'b10
    } seq_state_t;

endpackage : reset_and_brownout_control_pkg
`default_nettype wire

// ---- reset_and_brownout_control_test.sv ----
// Self-checking testbench of the reset and brown-out block.
`timescale 1ns/1ps
`default_nettype none

module reset_and_brownout_control_test;
    import reset_and_brownout_control_pkg::*;

    localparam int POWERUP_DELAY_TIMER = 20;

    logic       mclk;
    logic       rst_b     = 1'h0;
    logic       por_ok    = 1'h1;
    logic       below     = 1'h0;
    logic       sleep     = 1'h0;
    logic       lvl       = 1'h0;
    logic       powerup_delay_timer_n    = 1'h0;
    logic       pin_en    = 1'h1;
    logic       lp_en     = 1'h1;
    logic       wr_en     = 1'h0;
    logic       rd_en     = 1'h0;
    logic [3:0] addr      = 4'h0;
    logic [7:0] wdata     = 8'h00;
    logic [6:0] src       = 7'h00;
    bor_mode_t  mode      = BOR_OFF;
    logic [7:0] rdata;
    logic       dev_rst, det_on, bg_on, lvl_out, bo;
    int         bo_hits   = 0;
    int         errors    = 0;
    int         cmp_count = 0;
    int         cycles    = 0;

    reset_and_brownout_control #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER)) reset_and_brownout_control_inst (
        .mclk(mclk), .rst_b(rst_b), .por_supply_ok(por_ok), .supply_below_threshold(below),
        .lowpower_brownout_en(lp_en), .lowpower_brownout_req(src[5]), .external_reset_pin_en(pin_en),
        .external_reset_pin_b(~src[4]), .watchdog_reset_req(src[0]), .reset_instr_req(src[1]),
        .stack_overflow_req(src[2]), .stack_underflow_req(src[3]), .prog_mode_exit(src[6]),
        .sleep_mode(sleep), .brownout_mode_sel(mode), .brownout_level_sel(lvl),
        .powerup_delay_enable_n(powerup_delay_timer_n), .reg_addr(addr), .reg_wr_data(wdata), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_rd_data(rdata), .device_reset(dev_rst), .brownout_detector_on(det_on),
        .bandgap_on(bg_on), .brownout_level_out(lvl_out), .combined_brownout(bo));

    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (bo === 1'h1) bo_hits <= bo_hits + 1;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'h1;
        @(posedge mclk);
        wr_en <= 1'h0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'h1;
        @(posedge mclk);
        rd_en <= 1'h0;
        #1 check(what, exp, rdata);
        @(posedge mclk);
        #1 check({what, " after"}, 8'h00, rdata);
    endtask : rd

    task automatic wait_release(input int lo, input int hi, input string what);
        int n;
        n = 0;
        while (dev_rst !== 1'h0 && n < 2000) begin
            tick(1);
            n++;
        end
        check(what, 8'h01, 8'(n >= lo && n <= hi));
    endtask : wait_release

    task automatic t_regs();
        rd(4'h0, 8'h80, "reset value");
        wr(4'h0, 8'hff);
        rd(4'h0, 8'hc0, "written value");
        wr(4'h5, 8'h00);
        rd(4'h0, 8'hc0, "unmapped write");
        rd(4'h5, 8'h00, "unmapped read");
        wr(4'h0, 8'h80);
    endtask : t_regs

    task automatic t_power();
        por_ok <= 1'h0;
        tick(30);
        check("held low supply", 8'h01, dev_rst);
        por_ok <= 1'h1;
        wait_release(POWERUP_DELAY_TIMER, POWERUP_DELAY_TIMER + 6, "delay length");
        powerup_delay_timer_n <= 1'h1;
        por_ok <= 1'h0;
        tick(3);
        por_ok <= 1'h1;
        wait_release(0, 6, "delay skipped");
        powerup_delay_timer_n <= 1'h0;
    endtask : t_power

    task automatic t_sources();
        for (int i = 0; i < 7; i++) begin
            src <= 7'(1 << i);
            tick(3);
            check("source asserts", 8'h01, dev_rst);
            if (i == 5) check("combined", 8'h01, bo);
            src <= 7'h00;
            if (i < 5) wait_release(0, 4, "plain source");
            else wait_release(POWERUP_DELAY_TIMER, POWERUP_DELAY_TIMER + 8, "power source");
        end
        pin_en <= 1'h0;
        src    <= 7'h10;
        tick(5);
        check("pin disabled", 8'h00, dev_rst);
        src    <= 7'h00;
        pin_en <= 1'h1;
        lp_en  <= 1'h0;
        tick(1);
        src    <= 7'h20;
        tick(5);
        check("low-power disabled", 8'h00, dev_rst);
        check("low-power disabled bo", 8'h00, bo);
        src    <= 7'h00;
        lp_en  <= 1'h1;
    endtask : t_sources

    task automatic t_brownout();
        int base;
        mode <= BOR_ON;
        tick(600);
        rd(4'h0, 8'h81, "ready in mode on");
        wr(4'h0, 8'h40);
        base = bo_hits;
        below <= 1'h1;
        tick(50);
        check("dip ignored", 8'h00, dev_rst);
        below <= 1'h0;
        tick(5);
        check("short dip", 8'h00, 8'(bo_hits != base));
        below <= 1'h1;
        tick(110);
        check("long dip", 8'h01, 8'(bo_hits != base));
        check("brown-out reset", 8'h01, dev_rst);
        tick(20);
        below <= 1'h0;
        wait_release(POWERUP_DELAY_TIMER, POWERUP_DELAY_TIMER + 8, "delay after brown-out");
        rd(4'h0, 8'h81, "brown-out clears bits");
        lvl <= 1'h1;
        tick(3);
        check("level select", 8'h01, lvl_out);
    endtask : t_brownout

    task automatic t_modes();
        mode <= BOR_SW;
        wr(4'h0, 8'h00);
        tick(3);
        check("sw disabled", 8'h00, det_on);
        rd(4'h0, 8'h00, "sw disabled reads");
        wr(4'h0, 8'h80);
        tick(3);
        check("no start wait", 8'h00, dev_rst);
        rd(4'h0, 8'h80, "sw not ready yet");
        tick(600);
        check("sw enabled", 8'h01, det_on);
        rd(4'h0, 8'h81, "sw ready");
        sleep <= 1'h1;
        tick(3);
        check("sw in sleep", 8'h01, det_on);
        wr(4'h0, 8'h40);
        tick(3);
        check("fast start", 8'h01, bg_on);
        mode <= BOR_OFF;
        tick(3);
        check("fast start unused", 8'h00, bg_on);
        mode <= BOR_NOSLEEP;
        wr(4'h0, 8'h80);
        tick(600);
        check("off in sleep", 8'h00, det_on);
        sleep <= 1'h0;
        tick(3);
        check("wake waits ready", 8'h01, dev_rst);
        tick(600);
        check("on when awake", 8'h01, det_on);
        check("wake released", 8'h00, dev_rst);
    endtask : t_modes

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'h1;
        tick(1);
        wait_release(POWERUP_DELAY_TIMER, POWERUP_DELAY_TIMER + 6, "delay after reset");
        t_regs();
        t_power();
        t_sources();
        t_brownout();
        t_modes();
        wrap_up();
    end

endmodule : reset_and_brownout_control_test

`default_nettype wire
